// ### piib_regs.svh
`ifndef PIIB_REGS_SVH
`define PIIB_REGS_SVH
// Notes on behaviour
// [R1] Duty channel 3 match sets its priority flag directly, no local flag.
// [R2] Call only with global, priority enable, stack not full; call clears both.
// [R3] Boundary source is its own vector; conversion ends share group 2.
// [R4] Boundary flag raised when normal or scan data meets selected bound test.
// [R5] Conversion and scan ends set local flags, forwarded only when enabled.
// [R6] Software clears the conversion and scan end flags itself.
// [R7] Timer P and A matches set flags, each enabled, feeding shared group.
// [R8] Software clears timer match flags after servicing.
// [R9] Serial source sits in group 7, forwarded only when its enable is set.
// [R10] Serial flag set by any of six serial conditions.
// [R11] Software clears serial flag; serial unit clears its own status bits.
// [R12] Two-wire flag set on byte, address match or time-out, enable gated.
// [R13] Software clears the two-wire flag after servicing.
// [R14] Time-base overflow sets its flag in group 7, enable gated.
// [R15] Software clears the time-base flag after each service.
// [R16] Time-base clock is system clock over 4 or the dedicated tick.
// [R17] Period select 0..3 gives overflow every 2^12 .. 2^15 ticks.
// [R18] Servicing a group clears only the group priority flag.
// [R19] Any priority flag rising issues a wake pulse regardless of enables.
// [R20] Local flags set regardless of enable; enable gates forwarding only.

// Priority flag indices, lowest index is picked first
`define PIIB_NPRI 5
`define PIIB_IDX_DUTY3 0
`define PIIB_IDX_BOUND 1
`define PIIB_IDX_MF2 2
`define PIIB_IDX_MFTM 3
`define PIIB_IDX_MF7 4
`define PIIB_DATA_W 12
`define PIIB_TB_PRESCALE 4
`define PIIB_TB_SEL_RST 2'h3
`define PIIB_TB_CNT_W 15
`define PIIB_TB_BASE_EXP 12
`endif

// ### piib_pkg.sv
package piib_pkg;
    typedef logic [11:0] piib_data_t;

    typedef struct packed {
        logic tx_empty;
        logic tx_idle;
        logic rx_avail;
        logic rx_overrun;
        logic addr_detect;
        logic rx_wake;
    } piib_serial_evt_t;

    typedef struct packed {
        logic byte_done;
        logic addr_match;
        logic timeout;
    } piib_two_wire_evt_t;

    typedef struct packed {
        logic conv_valid;
        piib_data_t conv_result;
        logic scan_valid;
        piib_data_t scan_result;
        piib_data_t upper_bound;
        piib_data_t lower_bound;
        logic upper_bound_compare_en;
        logic lower_bound_compare_en;
    } piib_adc_t;

    typedef struct packed {
        logic normal_conv_end;
        logic scan_end;
        logic serial;
        logic two_wire;
        logic timebase;
    } piib_clr_t;

    typedef struct packed {
        logic normal_conv_end_flag;
        logic scan_end_flag;
        logic serial_irq_flag;
        logic two_wire_irq_flag;
        logic timebase_flag;
    } piib_flags_t;
endpackage : piib_pkg

// ### piib_top.sv
`timescale 1ns/1ns
`include "piib_regs.svh"

module piib_top import piib_pkg::*; #(
    parameter int NTM = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic duty_ch3_match_irq,
    input wire piib_adc_t adc,
    input wire logic normal_conv_done,
    input wire logic scan_done,
    input wire logic normal_conv_end_enable,
    input wire logic scan_end_enable,
    input wire logic [NTM-1:0] timer_p_match,
    input wire logic [NTM-1:0] timer_a_match,
    input wire logic [NTM-1:0] timer_p_match_enable,
    input wire logic [NTM-1:0] timer_a_match_enable,
    input wire logic [NTM-1:0] timer_p_clr,
    input wire logic [NTM-1:0] timer_a_clr,
    input wire piib_serial_evt_t serial_evt,
    input wire logic serial_irq_enable,
    input wire piib_two_wire_evt_t two_wire_evt,
    input wire logic two_wire_irq_enable,
    input wire logic timebase_irq_enable,
    input wire logic timebase_on,
    input wire logic timebase_sys_clk_sel,
    input wire logic [1:0] period_select,
    input wire logic dedicated_tick_clock,
    input wire piib_clr_t flag_clr,
    input wire logic [`PIIB_NPRI-1:0] priority_enable,
    input wire logic [`PIIB_NPRI-1:0] pri_sw_set,
    input wire logic [`PIIB_NPRI-1:0] pri_sw_clr,
    input wire logic global_irq_enable_set,
    input wire logic global_irq_enable_clr,
    input wire logic stack_full,
    output piib_flags_t flags,
    output logic [NTM-1:0] timer_p_match_flag,
    output logic [NTM-1:0] timer_a_match_flag,
    output logic [`PIIB_NPRI-1:0] priority_request_flag,
    output logic global_irq_enable,
    output logic vector_call,
    output logic [2:0] vector_id,
    output logic wake
);
    // ------------------------------------------------------------
    // Boundary comparison
    // ------------------------------------------------------------
    // Both enables: inside window; one enable: outside that bound
    function automatic logic bound_hit(input piib_data_t d, input piib_adc_t a);
        logic hi;
        logic lo;
        hi = d > a.upper_bound;
        lo = d < a.lower_bound;
        unique case ({a.upper_bound_compare_en, a.lower_bound_compare_en})
            2'h0: bound_hit = 1'b0;
            2'h1: bound_hit = lo;
            2'h2: bound_hit = hi;
            2'h3: bound_hit = !hi && !lo;
        endcase
    endfunction : bound_hit

    logic bnd_evt;
    assign bnd_evt = (adc.conv_valid && bound_hit(adc.conv_result, adc)) ||
                     (adc.scan_valid && bound_hit(adc.scan_result, adc)); // see [R4]

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    logic [1:0] pre_ff;
    logic [1:0] nxt_pre;
    logic [`PIIB_TB_CNT_W-1:0] tb_cnt_ff;
    logic [`PIIB_TB_CNT_W-1:0] nxt_tb_cnt;
    logic tb_tick;
    logic tb_ovf;
    logic [`PIIB_TB_CNT_W-1:0] tb_mask;

    always_comb begin
        nxt_pre = pre_ff + 2'h1;
        tb_tick = timebase_sys_clk_sel ? (pre_ff == 2'(`PIIB_TB_PRESCALE - 1))
                                       : dedicated_tick_clock; // see [R16]
        tb_mask = ~(`PIIB_TB_CNT_W'('1) << (`PIIB_TB_BASE_EXP + 32'(period_select))); // see [R17]
        tb_ovf = timebase_on && tb_tick && ((tb_cnt_ff & tb_mask) == tb_mask);
        nxt_tb_cnt = tb_cnt_ff;
        if (!timebase_on) begin
            nxt_tb_cnt = '0;
        end else if (tb_tick) begin
            nxt_tb_cnt = tb_cnt_ff + `PIIB_TB_CNT_W'(1);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pre_ff <= 2'h0;
            tb_cnt_ff <= '0;
        end else begin
            pre_ff <= nxt_pre;
            tb_cnt_ff <= nxt_tb_cnt;
        end
    end

    // ------------------------------------------------------------
    // Local source flags
    // ------------------------------------------------------------
    // Set wins over a software clear in the same cycle
    piib_flags_t flags_ff;
    piib_flags_t nxt_flags;
    logic [NTM-1:0] tmp_ff;
    logic [NTM-1:0] tma_ff;
    logic [NTM-1:0] nxt_tmp;
    logic [NTM-1:0] nxt_tma;

    always_comb begin
        nxt_flags.normal_conv_end_flag = normal_conv_done ||
            (flags_ff.normal_conv_end_flag && !flag_clr.normal_conv_end); // see [R5] see [R6]
        nxt_flags.scan_end_flag = scan_done ||
            (flags_ff.scan_end_flag && !flag_clr.scan_end); // see [R5] see [R6]
        nxt_flags.serial_irq_flag = (|serial_evt) ||
            (flags_ff.serial_irq_flag && !flag_clr.serial); // see [R10] see [R11]
        nxt_flags.two_wire_irq_flag = (|two_wire_evt) ||
            (flags_ff.two_wire_irq_flag && !flag_clr.two_wire); // see [R12] see [R13]
        nxt_flags.timebase_flag = tb_ovf ||
            (flags_ff.timebase_flag && !flag_clr.timebase); // see [R14] see [R15]
        nxt_tmp = timer_p_match | (tmp_ff & ~timer_p_clr); // see [R7] see [R8] see [R20]
        nxt_tma = timer_a_match | (tma_ff & ~timer_a_clr); // see [R7] see [R8] see [R20]
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_ff <= '0;
            tmp_ff <= '0;
            tma_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
            tmp_ff <= nxt_tmp;
            tma_ff <= nxt_tma;
        end
    end

    // ------------------------------------------------------------
    // Group forwarding
    // ------------------------------------------------------------
    // Groups set on a rising gated request so a standing local flag
    // does not re-raise the group right after service.
    logic mf2_req;
    logic mftm_req;
    logic mf7_req;
    logic [2:0] req_ff;
    logic [2:0] nxt_req;

    always_comb begin
        mf2_req = (flags_ff.normal_conv_end_flag && normal_conv_end_enable) ||
                  (flags_ff.scan_end_flag && scan_end_enable); // see [R3] see [R5]
        mftm_req = |((tmp_ff & timer_p_match_enable) | (tma_ff & timer_a_match_enable)); // see [R7]
        mf7_req = (flags_ff.serial_irq_flag && serial_irq_enable) ||
                  (flags_ff.two_wire_irq_flag && two_wire_irq_enable) ||
                  (flags_ff.timebase_flag && timebase_irq_enable); // see [R9] see [R12] see [R14]
        nxt_req = {mf7_req, mftm_req, mf2_req};
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_ff <= 3'h0;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // ------------------------------------------------------------
    // Priority flags, call issue and wake
    // ------------------------------------------------------------
    logic [`PIIB_NPRI-1:0] pri_ff;
    logic [`PIIB_NPRI-1:0] nxt_pri;
    logic [`PIIB_NPRI-1:0] pri_set;
    logic [`PIIB_NPRI-1:0] pend;
    logic [`PIIB_NPRI-1:0] svc;
    logic gie_ff;
    logic nxt_gie;
    logic call_ff;
    logic nxt_call;
    logic [2:0] vec_ff;
    logic [2:0] nxt_vec;
    logic wake_ff;
    logic nxt_wake;

    always_comb begin
        pri_set = pri_sw_set;
        pri_set[`PIIB_IDX_DUTY3] = pri_sw_set[`PIIB_IDX_DUTY3] | duty_ch3_match_irq; // see [R1]
        pri_set[`PIIB_IDX_BOUND] = pri_sw_set[`PIIB_IDX_BOUND] | bnd_evt; // see [R4]
        pri_set[`PIIB_IDX_MF2] = pri_sw_set[`PIIB_IDX_MF2] | (mf2_req & ~req_ff[0]);
        pri_set[`PIIB_IDX_MFTM] = pri_sw_set[`PIIB_IDX_MFTM] | (mftm_req & ~req_ff[1]);
        pri_set[`PIIB_IDX_MF7] = pri_sw_set[`PIIB_IDX_MF7] | (mf7_req & ~req_ff[2]);
        pend = pri_ff & priority_enable;
        svc = '0;
        nxt_call = 1'b0;
        nxt_vec = vec_ff;
        if (gie_ff && !stack_full && (|pend)) begin // see [R2]
            nxt_call = 1'b1;
            for (int i = `PIIB_NPRI - 1; i >= 0; i--) begin
                if (pend[i]) begin
                    nxt_vec = 3'(i);
                end
            end
            svc[nxt_vec] = 1'b1;
        end
        // Service clears only the group flag, local flags untouched
        nxt_pri = pri_set | (pri_ff & ~svc & ~pri_sw_clr); // see [R2] see [R18]
        nxt_gie = global_irq_enable_set ||
                  (gie_ff && !nxt_call && !global_irq_enable_clr); // see [R2]
        nxt_wake = |(nxt_pri & ~pri_ff); // see [R19]
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pri_ff <= '0;
            gie_ff <= 1'b0;
            call_ff <= 1'b0;
            vec_ff <= 3'h0;
            wake_ff <= 1'b0;
        end else begin
            pri_ff <= nxt_pri;
            gie_ff <= nxt_gie;
            call_ff <= nxt_call;
            vec_ff <= nxt_vec;
            wake_ff <= nxt_wake;
        end
    end

    assign flags = flags_ff;
    assign timer_p_match_flag = tmp_ff;
    assign timer_a_match_flag = tma_ff;
    assign priority_request_flag = pri_ff;
    assign global_irq_enable = gie_ff;
    assign vector_call = call_ff;
    assign vector_id = vec_ff;
    assign wake = wake_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // Group 7 must be quiet at the overflow, and still enabled a cycle later
    sequence s_tb_raise;
        tb_ovf && !mf7_req ##1 timebase_irq_enable;
    endsequence
    sequence s_tb_flag;
        flags_ff.timebase_flag ##1 pri_ff[`PIIB_IDX_MF7];
    endsequence

    AST_DUTY3_SET: assert property ( // see [R1]
        duty_ch3_match_irq |=> pri_ff[`PIIB_IDX_DUTY3])
        else $error("duty 3 match did not set its priority flag");
    AST_CALL_GATE: assert property ( // see [R2]
        call_ff |-> $past(gie_ff) && !$past(stack_full) && $past(pend[nxt_vec]))
        else $error("call issued without enables or with full stack");
    AST_CALL_CLEARS: assert property ( // see [R2]
        call_ff && !$past(global_irq_enable_set) |-> !gie_ff)
        else $error("call did not clear global enable");
    AST_BOUND_SET: assert property ( // see [R4]
        bnd_evt |=> pri_ff[`PIIB_IDX_BOUND])
        else $error("boundary hit did not set its flag");
    AST_CONV_END: assert property ( // see [R5]
        normal_conv_done ##1 !flag_clr.normal_conv_end |=> flags_ff.normal_conv_end_flag)
        else $error("conversion end flag lost");
    AST_TIMER_FLAG: assert property ( // see [R7]
        timer_p_match[0] |=> tmp_ff[0])
        else $error("timer P match flag not set");
    AST_SERIAL_SET: assert property ( // see [R10]
        (|serial_evt) |=> flags_ff.serial_irq_flag)
        else $error("serial condition did not set flag");
    AST_TB_FORWARD: assert property ( // see [R14]
        s_tb_raise |-> s_tb_flag)
        else $error("time-base overflow not forwarded to group 7");
    AST_GROUP_KEEP: assert property ( // see [R18]
        call_ff && vec_ff == 3'h4 && $past(flags_ff.serial_irq_flag) &&
        !$past(flag_clr.serial) |-> flags_ff.serial_irq_flag)
        else $error("group service cleared a local flag");
    AST_WAKE: assert property ( // see [R19]
        (|(pri_ff & ~$past(pri_ff))) |-> wake)
        else $error("priority flag rose without wake");
endmodule : piib_top

// ### piib_core_model.sv
`timescale 1ns/1ns
module piib_core_model #(
    parameter int RET_DELAY = 3
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic vector_call,
    input wire logic reti,
    output logic gie_set
);
    // ------------------------------
    // Return from service
    // ------------------------------
    int cnt;

    // A plain return (reti low) leaves interrupts off, as the core would
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            gie_set <= 1'b0;
        end else begin
            gie_set <= reti && cnt == 1;
            if (vector_call) begin
                cnt <= RET_DELAY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : piib_core_model

// ### testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("unexpected %s exp %0h got %0h", nm, e, g); \
        end \
    end
`define PULSE(s, v) \
    @(posedge clock); \
    s <= v; \
    @(posedge clock); \
    s <= '0; \
    #1;

module testbench import piib_pkg::*;;
    // ------------------------------
    // Stimulus and checks
    // ------------------------------
    logic clock, rstn, duty, nc_done, sc_done, nc_en, sc_en, ser_en, tw_en, tb_en, tb_on;
    logic tb_sys, tick, gie_set_tb, gie_clr, stk_full, reti, core_set, gie, vcall, wake;
    logic [1:0] psel, tp, ta, tpe, tae, tpc, tac, tpf, taf;
    logic [2:0] vid;
    logic [4:0] pe, pset, pclr, pri;
    piib_adc_t adc;
    piib_serial_evt_t sev;
    piib_two_wire_evt_t tev;
    piib_clr_t clr;
    piib_flags_t flags;
    int n_mismatch, comparisons, n;

    piib_top u_dut (.clock(clock), .rstn(rstn), .duty_ch3_match_irq(duty), .adc(adc),
        .normal_conv_done(nc_done), .scan_done(sc_done), .normal_conv_end_enable(nc_en),
        .scan_end_enable(sc_en), .timer_p_match(tp), .timer_a_match(ta),
        .timer_p_match_enable(tpe), .timer_a_match_enable(tae), .timer_p_clr(tpc),
        .timer_a_clr(tac), .serial_evt(sev), .serial_irq_enable(ser_en),
        .two_wire_evt(tev), .two_wire_irq_enable(tw_en), .timebase_irq_enable(tb_en),
        .timebase_on(tb_on), .timebase_sys_clk_sel(tb_sys), .period_select(psel),
        .dedicated_tick_clock(tick), .flag_clr(clr), .priority_enable(pe),
        .pri_sw_set(pset), .pri_sw_clr(pclr), .global_irq_enable_set(gie_set_tb | core_set),
        .global_irq_enable_clr(gie_clr), .stack_full(stk_full), .flags(flags),
        .timer_p_match_flag(tpf), .timer_a_match_flag(taf), .priority_request_flag(pri),
        .global_irq_enable(gie), .vector_call(vcall), .vector_id(vid), .wake(wake));
    piib_core_model u_core (.clock(clock), .rstn(rstn), .vector_call(vcall), .reti(reti),
        .gie_set(core_set));

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : step

    task automatic bail(input bit hit);
        if (hit) begin
            n_mismatch++;
            stop_test();
        end
    endtask : bail

    // Waits for a call, checks what it clears, then for the core's return
    task automatic wait_call(input logic [2:0] id);
        int i;
        for (i = 0; i < 20 && vcall !== 1'b1; i++) step(1);
        bail(i == 20);
        `CHK("vector_id", id, vid)
        `CHK("pri cleared", 1'b0, pri[id])
        `CHK("gie cleared", 1'b0, gie)
        for (i = 0; i < 20 && gie !== 1'b1; i++) step(1);
        bail(i == 20);
    endtask : wait_call

    // Measured between two fresh overflows; a stale flag would shift the start
    task automatic tb_period(output int p);
        int i;
        `PULSE(clr.timebase, 1'b1)
        for (i = 0; i < 40000 && flags.timebase_flag !== 1'b1; i++) step(1);
        `PULSE(clr.timebase, 1'b1)
        for (p = 2; p < 40000 && flags.timebase_flag !== 1'b1; p++) step(1);
        bail(i == 40000 || p == 40000);
    endtask : tb_period

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        {duty, nc_done, sc_done, nc_en, sc_en, ser_en, tw_en, tb_en, tb_on, tb_sys} = '0;
        {gie_set_tb, gie_clr, rstn, psel, tp, ta, tpe, tae, tpc, tac, pset, pclr} = '0;
        {sev, tev, clr} = '0;
        {tick, stk_full, reti, pe} = '1;
        adc = '{conv_valid: 1'b0, conv_result: 12'h800, scan_valid: 1'b0,
            scan_result: 12'h0FF, upper_bound: 12'h800, lower_bound: 12'h100,
            upper_bound_compare_en: 1'b1, lower_bound_compare_en: 1'b0};
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        step(1);
        `CHK("outputs", 20'h0, {flags, tpf, taf, pri, gie, vcall, vid, wake})
        $display("test reset done");
        // Wake must fire even with interrupts globally off
        `PULSE(duty, 1'b1)
        `CHK("pri", 5'h01, pri)
        `CHK("wake", 1'b1, wake)
        `PULSE(pclr, 5'h01)
        `CHK("wake", 1'b0, wake)
        `PULSE(gie_set_tb, 1'b1)
        `PULSE(duty, 1'b1)
        step(3);
        `CHK("held by stack", 6'h21, {gie, pri})
        @(posedge clock);
        stk_full <= 1'b0;
        wait_call(3'h0);
        $display("test duty3 done");
        // A full stack keeps a wrongly raised group flag standing, so it can be seen
        @(posedge clock);
        stk_full <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            if (i < 6) begin
                `PULSE(sev, piib_serial_evt_t'(6'h01 << i))
            end else begin
                `PULSE(tev, piib_two_wire_evt_t'(3'h1 << (i - 6)))
            end
            `CHK("evt flag", i < 6 ? 2'h2 : 2'h1,
                {flags.serial_irq_flag, flags.two_wire_irq_flag})
            `PULSE(clr, '1)
        end
        `CHK("grp7 gated", 1'b0, pri[4])
        @(posedge clock);
        ser_en <= 1'b1;
        stk_full <= 1'b0;
        `PULSE(sev.rx_avail, 1'b1)
        wait_call(3'h4);
        `CHK("serial kept", 1'b1, flags.serial_irq_flag)
        `PULSE(clr.serial, 1'b1)
        $display("test group7 done");
        @(posedge clock);
        nc_en <= 1'b1;
        `PULSE(nc_done, 1'b1)
        wait_call(3'h2);
        `CHK("conv end kept", 1'b1, flags.normal_conv_end_flag)
        `PULSE(clr.normal_conv_end, 1'b1)
        @(posedge clock);
        stk_full <= 1'b1;
        `PULSE(sc_done, 1'b1)
        step(3);
        `CHK("scan end", 2'h2, {flags.scan_end_flag, pri[2]})
        `PULSE(clr.scan_end, 1'b1)
        // Equal to the upper bound is not above it
        `PULSE(adc.conv_valid, 1'b1)
        step(2);
        `CHK("bound", 1'b0, pri[1])
        @(posedge clock);
        stk_full <= 1'b0;
        adc.conv_result <= 12'h801;
        `PULSE(adc.conv_valid, 1'b1)
        wait_call(3'h1);
        @(posedge clock);
        {adc.upper_bound_compare_en, adc.lower_bound_compare_en} <= 2'h1;
        `PULSE(adc.scan_valid, 1'b1)
        wait_call(3'h1);
        // Both bounds enabled: a hit is a value inside the window
        @(posedge clock);
        {adc.upper_bound_compare_en, adc.lower_bound_compare_en} <= 2'h3;
        adc.conv_result <= 12'h400;
        `PULSE(adc.conv_valid, 1'b1)
        wait_call(3'h1);
        $display("test converter done");
        @(posedge clock);
        stk_full <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            `PULSE({tp, ta}, 4'h1 << i)
            `CHK("timer flags", 4'h1 << i, {tpf, taf})
            `PULSE({tpc, tac}, 4'h1 << i)
        end
        `CHK("timer grp gated", 1'b0, pri[3])
        @(posedge clock);
        tae <= 2'h2;
        stk_full <= 1'b0;
        `PULSE(ta, 2'h2)
        wait_call(3'h3);
        `PULSE(tac, 2'h2)
        $display("test timer done");
        `PULSE(gie_clr, 1'b1)
        `CHK("gie off", 1'b0, gie)
        @(posedge clock);
        {tb_on, tb_en} <= 2'h3;
        for (int c = 0; c < 4; c++) begin
            @(posedge clock);
            psel <= c == 1 ? 2'h1 : c == 3 ? 2'h2 : 2'h0;
            tb_sys <= c == 2;
            tb_period(n);
            `CHK("tb period", c == 0 ? 4096 : c == 1 ? 8192 : 16384, n)
            `CHK("tb grp7", 1'b1, pri[4])
        end
        $display("test timebase done");
        stop_test();
    end
endmodule : testbench
